/* ccu_pkg.sv */
// Shared constants and types of the sixteen channel capture/compare array.
package ccu_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_CH  = 16;          // Channel registers.
  localparam int NUM_PIN = 10;          // Channels that own a pin.
  localparam int NUM_DBL = NUM_CH - NUM_PIN; // Partners for paired pins.
  localparam int TW      = 16;          // Timer and register width.
  localparam int AW      = 8;           // Register address width.
  localparam int PRE_W   = 10;          // Free running prescaler width.

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_A_CNT = 8'h01;
  localparam logic [7:0] ADDR_A_REL = 8'h02;
  localparam logic [7:0] ADDR_B_CNT = 8'h03;
  localparam logic [7:0] ADDR_B_REL = 8'h04;
  localparam logic [7:0] ADDR_STAT  = 8'h05;
  localparam logic [7:0] ADDR_MASK  = 8'h06;
  localparam logic [7:0] ADDR_DBL   = 8'h07;
  localparam logic [7:0] ADDR_SGL   = 8'h08;
  localparam logic [3:0] PAGE_CFG   = 4'h1;  // 0x10 + channel.
  localparam logic [3:0] PAGE_VAL   = 4'h2;  // 0x20 + channel.

  // ----------------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_A_SEL = 0;        // Three bit clock select, base a.
  localparam int CTRL_A_RUN = 3;
  localparam int CTRL_B_SEL = 4;        // Three bit clock select, base b.
  localparam int CTRL_B_RUN = 7;
  localparam int CTRL_STAG  = 8;        // Staggered operation.
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] TB_RST   = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [2:0]  SEL_NB   = 3'h6; // Neighbour timer overflow.
  localparam logic [2:0]  SEL_EXT  = 3'h7; // External count, base a only.
  localparam int          STAG_SHIFT = 3;  // Eight cycles when staggered.
  localparam logic [15:0] TB_MAX   = 16'hffff;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF, MODE_CAP, MODE_CMP0, MODE_CMP1, MODE_CMP2, MODE_CMP3
  } ch_mode_t;

  typedef struct packed {
    logic       tsel;      // 0 time_base_a, 1 time_base_b.
    logic [1:0] edge_sel;  // Bit 0 rising, bit 1 falling.
    ch_mode_t   mode;
  } ch_cfg_t;

  typedef struct packed {
    logic [15:0] cnt;      // Timer value.
    logic        upd;      // Value changed in the last edge.
    logic        ovf;      // Overflow with reload in the last edge.
  } tb_view_t;

  typedef struct packed {
    logic tog;
    logic set;
    logic clr;
  } pin_act_t;

endpackage

/* cc_channel.sv */
// One capture/compare channel register with its mode logic.
`timescale 1ns/1ps
module cc_channel (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  ccu_pkg::ch_cfg_t      cfg_i,
  input  wire logic             single_i,
  input  wire logic             arm_i,
  input  wire logic             wr_i,
  input  wire logic [15:0]      wdata_i,
  input  ccu_pkg::tb_view_t     tb_a_i,
  input  ccu_pkg::tb_view_t     tb_b_i,
  input  wire logic             rise_i,
  input  wire logic             fall_i,
  output logic [15:0]           value_o,
  output logic                  req_o,
  output ccu_pkg::pin_act_t     act_o
);
  import ccu_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] value;    // Channel register.
    logic        once;     // Event already seen in this timer period.
    logic        done;     // Single event consumed.
    logic        req;      // Request pulse.
    pin_act_t    act;      // Pin action pulse.
  } ch_st_t;

  ch_st_t   q;             // Registered state.
  ch_st_t   d;             // Next state.
  tb_view_t tb;            // The time base this channel follows.
  logic     cap_hit;       // Selected pin edge seen in capture mode.
  logic     cmp_hit;       // Timer just stepped onto the register value.

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d        = q;
    d.req    = 1'b0;
    d.act    = '0;
    tb       = cfg_i.tsel ? tb_b_i : tb_a_i;
    cap_hit  = (cfg_i.mode == MODE_CAP) &&
               ((cfg_i.edge_sel[0] && rise_i) ||
                (cfg_i.edge_sel[1] && fall_i));
    // Matching only on a fresh timer value keeps a stopped timer from
    // firing every cycle while it rests on the register value.
    cmp_hit  = (cfg_i.mode >= MODE_CMP0) && tb.upd &&
               (tb.cnt == q.value) && !q.done;
    if (arm_i) begin
      d.done = 1'b0;
    end
    // A new period re-enables the once-per-period modes.
    if (tb.ovf) begin
      d.once = 1'b0;
      if (cfg_i.mode == MODE_CMP3) begin
        d.act.clr = 1'b1;
      end
    end
    // Software write first, so a capture in the same cycle wins.
    if (wr_i) begin
      d.value = wdata_i;
    end
    if (cap_hit && !q.done) begin
      d.value = tb.cnt;
      d.req   = 1'b1;
      d.done  = single_i;
    end else if (cmp_hit) begin
      unique case (cfg_i.mode)
        MODE_CMP0: begin
          d.req = 1'b1;
        end
        MODE_CMP1: begin
          d.req     = 1'b1;
          d.act.tog = 1'b1;
        end
        MODE_CMP2: begin
          d.req  = !d.once;
          d.once = 1'b1;
        end
        MODE_CMP3: begin
          d.req     = !d.once;
          d.act.set = !d.once;
          d.once    = 1'b1;
        end
        default: begin
          d.req = 1'b0;
        end
      endcase
      d.done = single_i && d.req;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign value_o = q.value;
  assign req_o   = q.req;
  assign act_o   = q.act;

endmodule

/* sixteen_channel_capture_compare.sv */
// Sixteen channel capture/compare array with two reloadable time bases.
//
// How it works
// - Sixteen channels, one cycle, eight when staggered.
// - Two independent 16-bit timers with reloads.
// - Timers step on prescaler or neighbour overflow.
// - First timer may count external input edges.
// - Each channel picks its timer and function.
// - Ten channels own one pin each.
// - Mode zero: request on every match only.
// - Mode one: pin toggles on every match.
// - Mode two: at most one request per period.
// - Mode three: set on match, clear on overflow.
// - Paired registers both toggle one shared pin.
// - Single event option stops after one event.
// - Capture latches assigned timer on pin edge.
// - Each capture raises that channel's request.
// - Capture edge: rising, falling or both.
// - Compare continuously, act on equality.
`timescale 1ns/1ps
module sixteen_channel_capture_compare (
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  input  wire logic [ccu_pkg::AW-1:0]     addr_i,
  input  wire logic [15:0]                wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [15:0]                rdata_o,
  input  wire logic [ccu_pkg::NUM_PIN-1:0] cc_pin_i,
  output logic      [ccu_pkg::NUM_PIN-1:0] cc_pin_o,
  output logic      [ccu_pkg::NUM_PIN-1:0] cc_pin_oe_o,
  input  wire logic                       ext_count_i,
  input  wire logic                       neighbour_timer_overflow_source_i,
  output logic      [ccu_pkg::NUM_CH-1:0] ch_req_o,
  output logic                            irq_o
);
  import ccu_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0]             ctrl;      // Clock selects, run bits.
    logic [15:0]             time_base_a;
    logic [15:0]             a_rel;     // Reload value for base a.
    logic [15:0]             time_base_b;
    logic [15:0]             b_rel;     // Reload value for base b.
    logic                    a_upd;     // Base a stepped.
    logic                    a_ovf;     // Base a overflowed.
    logic                    b_upd;
    logic                    b_ovf;
    logic [PRE_W-1:0]        pre;       // Free running prescaler.
    logic [NUM_PIN-1:0]      pin_s1;    // Pin synchroniser, stage one.
    logic [NUM_PIN-1:0]      pin_s2;    // Pin synchroniser, stage two.
    logic [NUM_PIN-1:0]      pin_s3;    // Previous synchronised level.
    logic                    ext_s1;    // External count synchroniser.
    logic                    ext_s2;
    logic                    ext_s3;
    logic [NUM_CH-1:0]       stat;      // Pending flags.
    logic [NUM_CH-1:0]       mask;      // Interrupt enables.
    logic [NUM_DBL-1:0]      dbl;       // Paired pin enables.
    logic [NUM_CH-1:0]       sgl;       // Single event enables.
    ch_cfg_t [NUM_CH-1:0]    cfg;       // Channel configuration.
    logic [NUM_PIN-1:0]      pin;       // Pin output levels.
    logic [15:0]             rdata;     // Read data register.
  } st_t;

  st_t q;                               // Registered state.
  st_t d;                               // Next state.

  // Per channel wiring.
  logic [NUM_CH-1:0][15:0] ch_val;      // Channel register values.
  logic [NUM_CH-1:0]       ch_req;      // Channel request pulses.
  pin_act_t [NUM_CH-1:0]   ch_act;      // Channel pin actions.
  logic [NUM_CH-1:0]       ch_wr;       // Value write strobes.
  logic [NUM_CH-1:0]       ch_arm;      // Configuration write strobes.
  logic [NUM_PIN-1:0]      rise;        // Synchronised rising edges.
  logic [NUM_PIN-1:0]      fall;        // Synchronised falling edges.
  tb_view_t                tb_a;        // View of time_base_a.
  tb_view_t                tb_b;        // View of time_base_b.
  logic                    tick_a;      // Base a steps this cycle.
  logic                    tick_b;      // Base b steps this cycle.
  logic                    ext_rise;    // External count edge.
  logic [3:0]              ch_idx;      // Channel addressed on the bus.

  // ----------------------------------------------------------------------
  // Clock select
  // ----------------------------------------------------------------------
  // Returns the step enable for one time base. Selects below six pick a
  // prescaled system clock of 2^sel cycles, multiplied by eight when
  // staggered so the best resolution drops to eight cycles.
  function automatic logic tb_tick(input logic [2:0]       sel,
                                   input logic             run,
                                   input logic             stag,
                                   input logic [PRE_W-1:0] pre,
                                   input logic             nb,
                                   input logic             ext,
                                   input logic             ext_ok);
    logic [PRE_W-1:0] msk;
    logic [3:0]       sh;
    msk = '0;
    sh  = 4'({1'b0, sel}) + (stag ? 4'(STAG_SHIFT) : 4'h0);
    for (int i = 0; i < PRE_W; i++) begin
      msk[i] = (i < int'(sh));
    end
    if (!run) begin
      tb_tick = 1'b0;
    end else if (sel == SEL_NB) begin
      tb_tick = nb;
    end else if (sel == SEL_EXT) begin
      tb_tick = ext_ok && ext;
    end else begin
      tb_tick = ((pre & msk) == msk);
    end
  endfunction

  // Steps a timer, reloading on overflow so the period is set by the
  // reload value rather than always spanning the full 16-bit range.
  function automatic logic [17:0] tb_step(input logic [15:0] cnt,
                                          input logic [15:0] rel,
                                          input logic        tick);
    tb_step = {cnt, 2'b00};
    if (tick) begin
      if (cnt == TB_MAX) begin
        tb_step = {rel, 2'b11};
      end else begin
        tb_step = {cnt + 16'h0001, 2'b10};
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // Edge detection and bus decode
  // ----------------------------------------------------------------------
  // Edges look only at the second and third stages; the first stage
  // feeds nothing but the second, so a metastable level never spreads.
  assign rise     = q.pin_s2 & ~q.pin_s3;
  assign fall     = ~q.pin_s2 & q.pin_s3;
  assign ext_rise = q.ext_s2 && !q.ext_s3;
  assign ch_idx   = addr_i[3:0];
  assign tick_a   = tb_tick(q.ctrl[CTRL_A_SEL +: 3], q.ctrl[CTRL_A_RUN],
                            q.ctrl[CTRL_STAG], q.pre,
                            neighbour_timer_overflow_source_i,
                            ext_rise, 1'b1);
  assign tick_b   = tb_tick(q.ctrl[CTRL_B_SEL +: 3], q.ctrl[CTRL_B_RUN],
                            q.ctrl[CTRL_STAG], q.pre,
                            neighbour_timer_overflow_source_i,
                            ext_rise, 1'b0);
  assign tb_a     = '{cnt: q.time_base_a, upd: q.a_upd, ovf: q.a_ovf};
  assign tb_b     = '{cnt: q.time_base_b, upd: q.b_upd, ovf: q.b_ovf};

  // Write strobes toward the channels, one per channel register.
  always_comb begin
    ch_wr  = '0;
    ch_arm = '0;
    if (wr_i && (addr_i[7:4] == PAGE_VAL)) begin
      ch_wr[ch_idx] = 1'b1;
    end
    if (wr_i && (addr_i[7:4] == PAGE_CFG)) begin
      ch_arm[ch_idx] = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    // Channels without a pin never see an edge, so capture stays idle.
    logic r_in;
    logic f_in;
    if (c < NUM_PIN) begin : g_pin
      assign r_in = rise[c];
      assign f_in = fall[c];
    end else begin : g_nopin
      assign r_in = 1'b0;
      assign f_in = 1'b0;
    end
    cc_channel u_ch (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .cfg_i      (q.cfg[c]),
      .single_i   (q.sgl[c]),
      .arm_i      (ch_arm[c]),
      .wr_i       (ch_wr[c]),
      .wdata_i    (wdata_i),
      .tb_a_i     (tb_a),
      .tb_b_i     (tb_b),
      .rise_i     (r_in),
      .fall_i     (f_in),
      .value_o    (ch_val[c]),
      .req_o      (ch_req[c]),
      .act_o      (ch_act[c])
    );
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [17:0] sa;
    logic [17:0] sb;
    sa = tb_step(q.time_base_a, q.a_rel, tick_a);
    sb = tb_step(q.time_base_b, q.b_rel, tick_b);
    d = q;
    // Synchronisers and prescaler.
    d.pin_s1 = cc_pin_i;
    d.pin_s2 = q.pin_s1;
    d.pin_s3 = q.pin_s2;
    d.ext_s1 = ext_count_i;
    d.ext_s2 = q.ext_s1;
    d.ext_s3 = q.ext_s2;
    d.pre    = q.pre + 10'h001;
    // Time bases; a software write to a counter overrides its step.
    d.time_base_a = sa[17:2];
    d.a_upd       = sa[1];
    d.a_ovf       = sa[0];
    d.time_base_b = sb[17:2];
    d.b_upd       = sb[1];
    d.b_ovf       = sb[0];
    // Pins: clear first, then set, so a match on the reload value of
    // a mode three channel still leaves the pin high.
    for (int p = 0; p < NUM_PIN; p++) begin
      if (ch_act[p].tog) begin
        d.pin[p] = !d.pin[p];
      end
      if (ch_act[p].clr) begin
        d.pin[p] = 1'b0;
      end
      if (ch_act[p].set) begin
        d.pin[p] = 1'b1;
      end
      if (p < NUM_DBL) begin
        if (q.dbl[p] && ch_req[p + NUM_PIN]) begin
          d.pin[p] = !d.pin[p];
        end
      end
    end
    // Pending flags: a request in the clearing cycle survives.
    if (wr_i && (addr_i == ADDR_STAT)) begin
      d.stat = q.stat & ~wdata_i;
    end
    d.stat = d.stat | ch_req;
    // Register writes.
    if (wr_i) begin
      unique case (addr_i)
        ADDR_CTRL: begin
          d.ctrl = wdata_i;
        end
        ADDR_A_CNT: begin
          d.time_base_a = wdata_i;
          d.a_upd       = 1'b0;
          d.a_ovf       = 1'b0;
        end
        ADDR_A_REL: begin
          d.a_rel = wdata_i;
        end
        ADDR_B_CNT: begin
          d.time_base_b = wdata_i;
          d.b_upd       = 1'b0;
          d.b_ovf       = 1'b0;
        end
        ADDR_B_REL: begin
          d.b_rel = wdata_i;
        end
        ADDR_MASK: begin
          d.mask = wdata_i;
        end
        ADDR_DBL: begin
          d.dbl = wdata_i[NUM_DBL-1:0];
        end
        ADDR_SGL: begin
          d.sgl = wdata_i;
        end
        default: begin
          if (addr_i[7:4] == PAGE_CFG) begin
            d.cfg[ch_idx] = ch_cfg_t'(wdata_i[5:0]);
          end
        end
      endcase
    end
    // Read data stands in the cycle after the strobe only.
    d.rdata = 16'h0000;
    if (rd_i) begin
      unique case (addr_i)
        ADDR_CTRL: begin
          d.rdata = q.ctrl;
        end
        ADDR_A_CNT: begin
          d.rdata = q.time_base_a;
        end
        ADDR_A_REL: begin
          d.rdata = q.a_rel;
        end
        ADDR_B_CNT: begin
          d.rdata = q.time_base_b;
        end
        ADDR_B_REL: begin
          d.rdata = q.b_rel;
        end
        ADDR_STAT: begin
          d.rdata = q.stat;
        end
        ADDR_MASK: begin
          d.rdata = q.mask;
        end
        ADDR_DBL: begin
          d.rdata = {10'h000, q.dbl};
        end
        ADDR_SGL: begin
          d.rdata = q.sgl;
        end
        default: begin
          if (addr_i[7:4] == PAGE_CFG) begin
            d.rdata = {10'h000, q.cfg[ch_idx]};
          end else if (addr_i[7:4] == PAGE_VAL) begin
            d.rdata = ch_val[ch_idx];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q             <= '0;
      q.ctrl        <= CTRL_RST;
      q.time_base_a <= TB_RST;
      q.time_base_b <= TB_RST;
      q.mask        <= MASK_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // A pin is driven only while its channel generates pin events or its pairing
  // is enabled, so an unpaired capture channel leaves the pad free.
  always_comb begin
    for (int p = 0; p < NUM_PIN; p++) begin
      cc_pin_oe_o[p] = (q.cfg[p].mode == MODE_CMP1) ||
                       (q.cfg[p].mode == MODE_CMP3);
      if (p < NUM_DBL) begin
        cc_pin_oe_o[p] = cc_pin_oe_o[p] || q.dbl[p];
      end
    end
  end

  assign cc_pin_o = q.pin;
  assign rdata_o  = q.rdata;
  assign ch_req_o = ch_req;
  assign irq_o    = |(q.stat & q.mask);

endmodule

/* ccu_checker.sv */
// Port-level assertions for the capture/compare array.
`timescale 1ns/1ps
module ccu_checker (
  input wire logic [0:0]               core_clk_i,
  input wire logic                     rst_i,
  input wire logic [ccu_pkg::AW-1:0]   addr_i,
  input wire logic [15:0]              wdata_i,
  input wire logic                     wr_i,
  input wire logic                     rd_i,
  input wire logic [15:0]              rdata_o,
  input wire logic [ccu_pkg::NUM_PIN-1:0] cc_pin_o,
  input wire logic [ccu_pkg::NUM_PIN-1:0] cc_pin_oe_o,
  input wire logic [ccu_pkg::NUM_CH-1:0]  ch_req_o,
  input wire logic                     irq_o
);
  import ccu_pkg::*;
  // ---------------------------------------------------------------
  // Helper state
  // ---------------------------------------------------------------
  logic [15:0] mask_q; // Shadow of the mask register.
  // Tracks mask writes so the irq gate can be judged at the ports.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_q <= 16'h0000;
    end else if (wr_i && addr_i == ADDR_MASK) begin
      mask_q <= wdata_i;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data outside a read slot");
  AST_RD_HOLE: assert property (rd_i && addr_i inside {[8'h09:8'h0f],
    [8'h30:8'hff]} |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  AST_OE_CFG: assert property ($changed(cc_pin_oe_o)
    |-> $past(wr_i)) else $error("pin enable moved without a write");
  AST_PIN_RISE: assert property ((cc_pin_o & ~$past(cc_pin_o)) != '0
    |-> $past(ch_req_o) != '0) else $error("pin rose without request");
  AST_IRQ_RISE: assert property ($rose(irq_o)
    |-> $past(wr_i) || $past(ch_req_o) != '0) else $error("stray irq");
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(wr_i))
    else $error("irq dropped without a write");
  AST_IRQ_MASK: assert property (irq_o |-> mask_q != 16'h0000)
    else $error("irq with everything masked");
  AST_QUIET: assert property ($fell(rst_i)
    |-> (ch_req_o == '0 && cc_pin_o == '0) [*3]) else $error("not quiet");
endmodule
bind sixteen_channel_capture_compare ccu_checker i_chk (.core_clk_i,
  .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cc_pin_o,
  .cc_pin_oe_o, .ch_req_o, .irq_o);

/* cc_pin_model.sv */
// Far-side model of the ten channel pins.
`timescale 1ns/1ps
module cc_pin_model (
  input  wire logic [9:0] drive_i,
  input  wire logic [9:0] oe_i,
  input  wire logic [9:0] lvl_i,
  output logic      [9:0] pin_o
);
  // A line reads back its own drive while enabled, else the outside
  // level; a pin may serve its own channel and a paired partner.
  always_comb pin_o = (oe_i & drive_i) | (~oe_i & lvl_i);
endmodule

/* sixteen_channel_capture_compare_bench.sv */
// Self-checking bench for the capture/compare array.
`timescale 1ns/1ps
module sixteen_channel_capture_compare_bench;
  import ccu_pkg::*;
  typedef struct packed {
    logic [3:0] ch;
    logic [7:0] cfg;
    logic [15:0] ctrl;
    logic [5:0] dbl;
    logic sgl;
    logic [7:0] nreq;
    logic [7:0] ned;
  } row_t;
  logic clk, rst, wr, rd, irq;
  logic ext = 1'b0;
  logic nb = 1'b0;
  logic [7:0] addr;
  logic [15:0] wd, rdat, req;
  logic [9:0] pin_in, pin_out, oe, lvl;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  // Counts over 128 cycles; a period is 16 steps of base a, 32 of b.
  row_t rows [11] = '{
    '{4'h0, 8'h02, 16'h0008, 6'h00, 1'b0, 8'd8, 8'd0},
    '{4'h0, 8'h04, 16'h0008, 6'h00, 1'b0, 8'd8, 8'd0},
    '{4'h0, 8'h03, 16'h0008, 6'h00, 1'b0, 8'd8, 8'd8},
    '{4'h0, 8'h05, 16'h0008, 6'h00, 1'b0, 8'd8, 8'd16},
    '{4'h0, 8'h03, 16'h0008, 6'h00, 1'b1, 8'd1, 8'd1},
    '{4'h2, 8'h23, 16'h0088, 6'h00, 1'b0, 8'd4, 8'd4},
    '{4'h0, 8'h02, 16'h0009, 6'h00, 1'b0, 8'd4, 8'd0},
    '{4'h0, 8'h02, 16'h000f, 6'h00, 1'b0, 8'd4, 8'd0},
    '{4'h0, 8'h02, 16'h000e, 6'h00, 1'b0, 8'd2, 8'd0},
    '{4'h0, 8'h02, 16'h0108, 6'h00, 1'b0, 8'd1, 8'd0},
    '{4'ha, 8'h03, 16'h0008, 6'h01, 1'b0, 8'd8, 8'd8}};
  sixteen_channel_capture_compare i_dut (.core_clk_i(clk), .rst_i(rst),
    .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat),
    .cc_pin_i(pin_in), .cc_pin_o(pin_out), .cc_pin_oe_o(oe),
    .ext_count_i(ext), .neighbour_timer_overflow_source_i(nb),
    .ch_req_o(req), .irq_o(irq));
  cc_pin_model i_pins (.drive_i(pin_out), .oe_i(oe), .lvl_i(lvl),
    .pin_o(pin_in));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // External count edge every two cycles, neighbour pulse every four.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ext <= ~ext;
    nb <= (cyc % 4 == 3);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(rdat, exp);
  endtask
  task automatic reset_values();
    rd_chk(ADDR_CTRL, CTRL_RST);
    rd_chk(ADDR_A_CNT, TB_RST);
    rd_chk(ADDR_MASK, MASK_RST);
    rd_chk(ADDR_STAT, 16'h0000);
    rd_chk(8'h0f, 16'h0000);
    wr_reg(ADDR_A_REL, 16'hfff0);
    rd_chk(ADDR_A_REL, 16'hfff0);
  endtask
  // Each row arms one channel, then counts requests and pin edges.
  task automatic compare_rows();
    row_t r;
    logic [7:0] nr, ne;
    logic last;
    int p;
    wr_reg(ADDR_B_REL, 16'hffe0);
    wr_reg(ADDR_A_CNT, 16'hfff0);
    wr_reg(ADDR_B_CNT, 16'hffe0);
    wr_reg({PAGE_VAL, 4'h0}, 16'hfff8);
    wr_reg({PAGE_VAL, 4'h2}, 16'hfff8);
    wr_reg({PAGE_VAL, 4'ha}, 16'hfff8);
    for (int i = 0; i < 11; i++) begin
      r = rows[i];
      p = (r.ch >= 10) ? r.ch - 10 : r.ch;
      wr_reg(ADDR_CTRL, r.ctrl);
      wr_reg(ADDR_DBL, {10'h000, r.dbl});
      wr_reg(ADDR_SGL, r.sgl ? 16'h0001 << r.ch : 16'h0000);
      repeat (8) @(posedge clk);
      wr_reg({PAGE_CFG, r.ch}, {8'h00, r.cfg});
      nr = 8'h00;
      ne = 8'h00;
      last = pin_out[p];
      repeat (128) begin
        @(posedge clk);
        if (req[r.ch] === 1'b1) nr++;
        if (pin_out[p] !== last) ne++;
        last = pin_out[p];
      end
      chk({15'h0000, oe[p]}, {15'h0000, r.ned != 8'd0});
      wr_reg({PAGE_CFG, r.ch}, 16'h0000);
      chk({8'h00, nr}, {8'h00, r.nreq});
      chk({8'h00, ne}, {8'h00, r.ned});
    end
  endtask
  // Stopped timer, so every capture must latch the same value.
  task automatic capture_edges();
    logic [7:0] nr;
    wr_reg(ADDR_CTRL, 16'h0000);
    wr_reg(ADDR_A_CNT, 16'h1234);
    wr_reg(ADDR_MASK, 16'hffff);
    for (int e = 1; e < 4; e++) begin
      wr_reg(ADDR_STAT, 16'hffff);
      wr_reg({PAGE_VAL, 4'h1}, 16'h0000);
      wr_reg({PAGE_CFG, 4'h1}, {11'h000, 2'(e), 3'h1});
      nr = 8'h00;
      for (int k = 0; k < 16; k++) begin
        lvl[1] <= (k < 8);
        @(posedge clk);
        if (req[1] === 1'b1) nr++;
      end
      chk({8'h00, nr}, (e == 3) ? 16'h0002 : 16'h0001);
      rd_chk({PAGE_VAL, 4'h1}, 16'h1234);
      chk({15'h0000, irq}, 16'h0001);
    end
    wr_reg(ADDR_STAT, 16'hffff);
    chk({15'h0000, irq}, 16'h0000);
  endtask
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    {rst, wr, rd} = 3'h4;
    {addr, wd, lvl} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    reset_values();
    compare_rows();
    capture_edges();
    tally_and_finish();
  end
endmodule
